// ==== design/adc_status_mode_regs.sv ====
// Purpose: Status word and mode word of the converter's serial control port
// Assumes: Frame decoder, CRC and conversion logic share mclk
// Notes:   Register port is the decoded request from the serial frame logic
//
// Notes on behaviour
// - Status bit 15 shows interface lock, resets 0
// - Status bit 14 sets on every resync
// - Status bit 13 flags configuration checksum change
// - Status bit 12 flags incoming checksum error
// - Status bit 11 shows polynomial: CCITT or ANSI
// - Status bit 10 reads 1 after reset
// - Status bits 9:8 give word length, reset 01
// - Status bits 3:0 flag new channel data
// - Mode word at 02h, reset 0510h, listed fields
// - Mode bits 13,12 enable map and input checksums
// - Writing 0 to mode bit 10 clears flag
// - Mode bit 4 enables serial timeout, reset 1
// - Mode bit 1: idle pin high or floating
`timescale 1ns/100ps
`default_nettype none

module adc_status_mode_regs
    import adc_regs_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                reset_n,
    input  wire reg_req_t            reg_req,
    output var  logic [15:0]         rd_data,
    output var  logic                rd_valid,
    input  wire logic                lock_state,
    input  wire logic                resync_event,
    input  wire logic                regmap_crc_change,
    input  wire logic                rx_crc_error,
    input  wire logic [CHANNELS-1:0] new_sample_event,
    input  wire logic [CHANNELS-1:0] sample_taken,
    output var  logic [15:0]         mode_word,
    output var  logic                regmap_crc_en,
    output var  logic                rx_crc_en,
    output var  logic                crc_poly_sel,
    output var  logic [1:0]          output_word_size,
    output var  logic                timeout_en,
    output var  logic                sample_pin_float_sel,
    output var  logic                sample_pin_out,
    output var  logic                sample_pin_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0]         mode_reg;
    logic                lock_reg;
    logic                resync_reg;
    logic                regmap_reg;
    logic                crc_err_reg;
    logic [CHANNELS-1:0] sample_flag_reg;
    logic [15:0]         rd_data_reg;
    logic                rd_valid_reg;
    logic                pin_out_reg;
    logic                pin_oe_reg;
    status_t             status_now;
    logic                status_read;
    logic                mode_write;

    assign status_read = reg_req.rd && (reg_req.addr == ADDR_STATUS);
    assign mode_write  = reg_req.wr && (reg_req.addr == ADDR_MODE);

    // ------------------------------------------------------------
    // Mode word
    // ------------------------------------------------------------
    // Status address is read-only, so only the mode address writes
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg <= MODE_RESET;
        end else if (mode_write) begin
            // Clearing bit 10 drops the reset-seen flag
            mode_reg <= reg_req.wdata & MODE_WR_MASK;
        end
    end

    // ------------------------------------------------------------
    // Lock indicator
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lock_reg <= 1'b0;
        end else begin
            lock_reg <= lock_state;
        end
    end

    // ------------------------------------------------------------
    // Sticky event flags
    // ------------------------------------------------------------
    // Cleared by a status read; an event in that same cycle wins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            resync_reg <= 1'b0;
        end else if (resync_event) begin
            resync_reg <= 1'b1;
        end else if (status_read) begin
            resync_reg <= 1'b0;
        end
    end

    // Checksum events count only while their check is enabled
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            regmap_reg <= 1'b0;
        end else if (regmap_crc_change && mode_reg[MODE_REGCRC_BIT]) begin
            regmap_reg <= 1'b1;
        end else if (status_read) begin
            regmap_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            crc_err_reg <= 1'b0;
        end else if (rx_crc_error && mode_reg[MODE_RXCRC_BIT]) begin
            crc_err_reg <= 1'b1;
        end else if (status_read) begin
            crc_err_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Per-channel new data flags
    // ------------------------------------------------------------
    // Cleared when the sample is taken; a fresh sample wins
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_sample
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    sample_flag_reg[ch] <= 1'b0;
                end else if (new_sample_event[ch]) begin
                    sample_flag_reg[ch] <= 1'b1;
                end else if (sample_taken[ch]) begin
                    sample_flag_reg[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------
    always_comb begin
        status_now                  = '0;
        status_now.lock             = lock_reg;
        status_now.resync_seen_flag = resync_reg;
        status_now.regmap_changed   = regmap_reg;
        status_now.rx_crc_error     = crc_err_reg;
        status_now.crc_poly         = mode_reg[MODE_POLY_BIT];
        status_now.reset_seen       = mode_reg[MODE_RESET_BIT];
        status_now.output_word_size = mode_reg[MODE_WLEN_LSB +: 2];
        status_now.reserved         = STATUS_RSVD_VAL;
        status_now.new_sample       = sample_flag_reg;
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped addresses read as zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_reg <= 16'h0000;
        end else if (reg_req.rd) begin
            if (reg_req.addr == ADDR_STATUS) begin
                rd_data_reg <= status_now;
            end else if (reg_req.addr == ADDR_MODE) begin
                rd_data_reg <= mode_reg;
            end else begin
                rd_data_reg <= 16'h0000;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= reg_req.rd;
        end
    end

    // ------------------------------------------------------------
    // Data-ready pin
    // ------------------------------------------------------------
    // Active low: driven low while any channel holds new data
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_out_reg <= 1'b1;
            pin_oe_reg  <= 1'b1;
        end else if (|sample_flag_reg) begin
            pin_out_reg <= 1'b0;
            pin_oe_reg  <= 1'b1;
        end else begin
            pin_out_reg <= 1'b1;
            pin_oe_reg  <= !mode_reg[MODE_FLOAT_BIT];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_data              = rd_data_reg;
    assign rd_valid             = rd_valid_reg;
    assign mode_word            = mode_reg;
    assign regmap_crc_en        = mode_reg[MODE_REGCRC_BIT];
    assign rx_crc_en            = mode_reg[MODE_RXCRC_BIT];
    assign crc_poly_sel         = mode_reg[MODE_POLY_BIT];
    assign output_word_size     = mode_reg[MODE_WLEN_LSB +: 2];
    assign timeout_en           = mode_reg[MODE_TMO_BIT];
    assign sample_pin_float_sel = mode_reg[MODE_FLOAT_BIT];
    assign sample_pin_out       = pin_out_reg;
    assign sample_pin_oe        = pin_oe_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    chk_lock_read: assert property (
        status_read |=> rd_data[15] == $past(lock_state, 2)
    ) else $error("lock bit does not follow lock input");

    chk_resync_sticky: assert property (
        resync_event |=> resync_reg
    ) else $error("resync flag lost");

    chk_resync_hold: assert property (
        (resync_reg && !status_read) |=> resync_reg
    ) else $error("resync flag dropped without a status read");

    chk_resync_read: assert property (
        status_read |=> rd_data[14] == $past(resync_reg)
    ) else $error("resync flag not reported on read");

    chk_regmap_set: assert property (
        (regmap_crc_change && mode_reg[MODE_REGCRC_BIT]) |=> regmap_reg
    ) else $error("map checksum change not flagged");

    chk_regmap_gated: assert property (
        (!regmap_reg && !mode_reg[MODE_REGCRC_BIT]) |=> !regmap_reg
    ) else $error("map checksum flag set while disabled");

    chk_crc_err_gated: assert property (
        (!crc_err_reg && !mode_reg[MODE_RXCRC_BIT]) |=> !crc_err_reg
    ) else $error("input checksum flag set while disabled");

    chk_crc_err_set: assert property (
        (rx_crc_error && mode_reg[MODE_RXCRC_BIT] && status_read) |=> crc_err_reg
    ) else $error("input checksum error lost against clear");

    chk_poly_mirror: assert property (
        status_read |=> rd_data[11] == $past(mode_reg[MODE_POLY_BIT])
    ) else $error("polynomial bit not mirrored");

    chk_reset_clear: assert property (
        (mode_write && !reg_req.wdata[MODE_RESET_BIT]) ##1 (status_read && !mode_write) |=> !rd_data[10]
    ) else $error("reset flag not cleared by write of zero");

    chk_wlen_mirror: assert property (
        status_read |=> rd_data[9:8] == $past(mode_reg[MODE_WLEN_LSB +: 2]) && rd_data[7:4] == 4'h0
    ) else $error("word length not mirrored");

    chk_sample_flag: assert property (
        (new_sample_event != '0) |=> (sample_flag_reg & $past(new_sample_event)) == $past(new_sample_event)
    ) else $error("new data flag not set");

    chk_sample_clear: assert property (
        (sample_taken != '0) |=> (sample_flag_reg & $past(sample_taken) & ~$past(new_sample_event)) == '0
    ) else $error("new data flag not cleared when taken");

    chk_mode_write: assert property (
        mode_write |=> mode_reg == ($past(reg_req.wdata) & MODE_WR_MASK)
    ) else $error("mode write not stored");

    chk_mode_hold: assert property (
        !mode_write |=> $stable(mode_reg)
    ) else $error("mode word changed without a write");

    chk_rd_answer: assert property (
        reg_req.rd |=> rd_valid
    ) else $error("read request not answered");

    chk_status_ro: assert property (
        (reg_req.wr && reg_req.addr == ADDR_STATUS) |=> $stable(mode_reg)
    ) else $error("status write changed state");

    chk_timeout_out: assert property (
        mode_write |=> timeout_en == $past(reg_req.wdata[MODE_TMO_BIT])
    ) else $error("timeout enable wrong");

    chk_pin_idle: assert property (
        (sample_flag_reg == '0) |=> sample_pin_out && (sample_pin_oe == !$past(mode_reg[MODE_FLOAT_BIT]))
    ) else $error("idle data-ready pin state wrong");

    chk_pin_active: assert property (
        (sample_flag_reg != '0) |=> !sample_pin_out && sample_pin_oe
    ) else $error("data-ready pin not asserted");

endmodule : adc_status_mode_regs

`default_nettype wire

// ==== shared/adc_regs_pkg.sv ====
// Purpose: Shared constants and carriers for the status and mode register bank
// Assumes: 16-bit register words, 8-bit register addresses
// Notes:   Offsets, field positions and reset values are named once here
package adc_regs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_STATUS     = 8'h01;
    localparam logic [7:0]  ADDR_MODE       = 8'h02;
    localparam logic [15:0] MODE_RESET      = 16'h0510;
    // Only documented fields hold state; reserved bits read as zero
    localparam logic [15:0] MODE_WR_MASK    = 16'h3F12;
    localparam int          CHANNELS        = 4;

    // ------------------------------------------------------------
    // Mode field positions
    // ------------------------------------------------------------
    localparam int          MODE_REGCRC_BIT = 13;
    localparam int          MODE_RXCRC_BIT  = 12;
    localparam int          MODE_POLY_BIT   = 11;
    localparam int          MODE_RESET_BIT  = 10;
    localparam int          MODE_WLEN_LSB   = 8;
    localparam int          MODE_TMO_BIT    = 4;
    localparam int          MODE_FLOAT_BIT  = 1;

    // ------------------------------------------------------------
    // Status reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  WLEN_24_BITS    = 2'h1;
    localparam logic [3:0]  STATUS_RSVD_VAL = 4'h0;

    typedef struct packed {
        logic       lock;
        logic       resync_seen_flag;
        logic       regmap_changed;
        logic       rx_crc_error;
        logic       crc_poly;
        logic       reset_seen;
        logic [1:0] output_word_size;
        logic [3:0] reserved;
        logic [3:0] new_sample;
    } status_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

endpackage : adc_regs_pkg

// ==== tb/adc_status_mode_regs_test.sv ====
// Purpose: Self-checking bench for the status and mode register bank
// Assumes: Read answers arrive in request order, one cycle after the take
// Notes:   Expected read words queue up and are matched by a monitor
`timescale 1ns/100ps
`default_nettype none

module adc_status_mode_regs_test;
    import adc_regs_pkg::*;
    logic        mclk, reset_n, lock_state, resync_event, regmap_crc_change, rx_crc_error, rd_valid;
    logic [3:0]  new_sample_event, sample_taken, ch4;
    logic [15:0] rd_data, mode_word, wd;
    logic [1:0]  output_word_size;
    logic        regmap_crc_en, rx_crc_en, crc_poly_sel, timeout_en, sample_pin_float_sel;
    logic        sample_pin_out, sample_pin_oe;
    reg_req_t    reg_req;
    logic [15:0] exp_q[$];
    int          failures, n_tests, seed, i;

    host_frame_model host (.mclk(mclk), .req(reg_req));

    adc_status_mode_regs dut (
        .mclk(mclk), .reset_n(reset_n), .reg_req(reg_req), .rd_data(rd_data), .rd_valid(rd_valid),
        .lock_state(lock_state), .resync_event(resync_event), .regmap_crc_change(regmap_crc_change),
        .rx_crc_error(rx_crc_error), .new_sample_event(new_sample_event), .sample_taken(sample_taken),
        .mode_word(mode_word), .regmap_crc_en(regmap_crc_en), .rx_crc_en(rx_crc_en),
        .crc_poly_sel(crc_poly_sel), .output_word_size(output_word_size), .timeout_en(timeout_en),
        .sample_pin_float_sel(sample_pin_float_sel), .sample_pin_out(sample_pin_out),
        .sample_pin_oe(sample_pin_oe));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check16

    function automatic int gap();
        return $unsigned($random(seed)) % 3;
    endfunction : gap

    function automatic logic [15:0] st(input logic lk, input logic [2:0] sk, input logic [15:0] m, input logic [3:0] ns);
        return {lk, sk, m[11:8], 4'h0, ns};
    endfunction : st

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.xfer(1'b1, 1'b0, a, 16'h0000, gap());
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.xfer(1'b0, 1'b1, a, d, gap());
    endtask : wr

    task automatic ev(input logic [2:0] e, input logic [3:0] ns, input logic [3:0] tk);
        @(posedge mclk);
        #1 {resync_event, regmap_crc_change, rx_crc_error} = e;
        new_sample_event = ns;
        sample_taken = tk;
        @(posedge mclk);
        #1 {resync_event, regmap_crc_change, rx_crc_error} = 3'h0;
        new_sample_event = 4'h0;
        sample_taken = 4'h0;
    endtask : ev

    // Field outputs compared as one word against the masked mode value
    task automatic chk_mode(input logic [15:0] m);
        @(posedge mclk);
        #1 check16("mode_word", m & MODE_WR_MASK, mode_word);
        check16("mode_fields", m & MODE_WR_MASK, {2'h0, regmap_crc_en, rx_crc_en, crc_poly_sel, mode_word[10],
                output_word_size, 3'h0, timeout_en, 2'h0, sample_pin_float_sel, 1'b0});
    endtask : chk_mode

    task automatic end_sim();
        if (exp_q.size() != 0) failures++;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // Read answers pair with the oldest note
    always @(posedge mclk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("[ERR] rd_data expected none seen %h", rd_data);
            end else begin
                check16("rd_data", exp_q.pop_front(), rd_data);
            end
        end
    end

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #50000;
        failures++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'hFDD1;
        reset_n = 1'b0;
        lock_state = 1'b0;
        {resync_event, regmap_crc_change, rx_crc_error} = 3'h0;
        new_sample_event = 4'h0;
        sample_taken = 4'h0;
        repeat (2) @(posedge mclk);
        #1 reset_n = 1'b1;
        chk_mode(MODE_RESET);
        check16("pin", 16'h0003, {14'h0, sample_pin_out, sample_pin_oe});
        rd(ADDR_STATUS, 16'h0500);
        rd(ADDR_MODE, 16'h0510);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            wd = 16'($random(seed));
            wd[9:8] = i[1:0];
            wr(ADDR_MODE, wd);
            chk_mode(wd);
            rd(ADDR_MODE, wd & MODE_WR_MASK);
            rd(ADDR_STATUS, st(1'b0, 3'h0, wd, 4'h0));
        end
        wr(ADDR_STATUS, 16'hFFFF);
        rd(ADDR_STATUS, st(1'b0, 3'h0, wd, 4'h0));
        rd(8'h05, 16'h0000);
        $display("test mirror done");
        wr(ADDR_MODE, 16'h3510);
        ev(3'h7, 4'h0, 4'h0);
        rd(ADDR_STATUS, st(1'b0, 3'h7, 16'h3510, 4'h0));
        rd(ADDR_STATUS, st(1'b0, 3'h0, 16'h3510, 4'h0));
        // Events in the cycle of a status read: the read sees old flags, the set wins
        exp_q.push_back(16'h0500);
        fork
            host.xfer(1'b1, 1'b0, ADDR_STATUS, 16'h0000, 0);
            ev(3'h7, 4'h0, 4'h0);
        join
        rd(ADDR_STATUS, st(1'b0, 3'h7, 16'h3510, 4'h0));
        wr(ADDR_MODE, 16'h0110);
        ev(3'h3, 4'h0, 4'h0);
        rd(ADDR_STATUS, st(1'b0, 3'h0, 16'h0110, 4'h0));
        lock_state = 1'b1;
        rd(ADDR_STATUS, st(1'b1, 3'h0, 16'h0110, 4'h0));
        lock_state = 1'b0;
        rd(ADDR_STATUS, st(1'b0, 3'h0, 16'h0110, 4'h0));
        $display("test events done");
        for (i = 0; i < 4; i++) begin
            ch4 = 4'h1 << i;
            // Taken in the same cycle as the new sample: the flag must stay
            ev(3'h0, ch4, ch4);
            repeat (2) @(posedge mclk);
            #1 check16("pin", 16'h0001, {14'h0, sample_pin_out, sample_pin_oe});
            rd(ADDR_STATUS, st(1'b0, 3'h0, 16'h0110, ch4));
            ev(3'h0, 4'h0, ch4);
        end
        rd(ADDR_STATUS, st(1'b0, 3'h0, 16'h0110, 4'h0));
        wr(ADDR_MODE, 16'h0112);
        repeat (3) @(posedge mclk);
        #1 check16("pin_oe", 16'h0000, {15'h0, sample_pin_oe});
        $display("test samples done");
        // Second reset must bring the cleared reset flag back
        @(posedge mclk);
        #1 reset_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1 reset_n = 1'b1;
        chk_mode(MODE_RESET);
        check16("pin", 16'h0003, {14'h0, sample_pin_out, sample_pin_oe});
        rd(ADDR_STATUS, 16'h0500);
        $display("test reset again done");
        repeat (3) @(posedge mclk);
        end_sim();
    end
endmodule : adc_status_mode_regs_test

`default_nettype wire

// ==== tb/host_frame_model.sv ====
// Purpose: Frame-logic side model issuing decoded register requests
// Assumes: Requests launched 1 ns after the rising edge of mclk
// Notes:   Released fields show inverted values so stale data never looks valid
`timescale 1ns/100ps
`default_nettype none

module host_frame_model
    import adc_regs_pkg::*;
(
    input  wire logic     mclk,
    output var  reg_req_t req
);
    initial req = '0;

    // Gap lets the model issue a request every other cycle or slowly
    task automatic xfer(input logic r, input logic w, input logic [7:0] a, input logic [15:0] d, input int gap);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        #1 req = '{rd: r, wr: w, addr: a, wdata: d};
        @(posedge mclk);
        #1 req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : xfer
endmodule : host_frame_model

`default_nettype wire
